// file: design/rtd_pkg.sv
/*
 * Constants shared by the ring trip detector: register map, field
 * layouts, reset values and timing figures.
 * Assumes an 8-bit register port decoded by the host interface logic.
 */
package rtd_pkg;

   // Register port geometry
   localparam int RTD_AW = 8;
   localparam int RTD_DW = 8;
   localparam int RTD_IW = 16;

   // Direct register addresses
   localparam logic [7:0] RTD_A_IRQ_PENDING = 8'h13;
   localparam logic [7:0] RTD_A_IRQ_ENABLE = 8'h16;
   localparam logic [7:0] RTD_A_IND_DATA_LO = 8'h1C;
   localparam logic [7:0] RTD_A_IND_DATA_HI = 8'h1D;
   localparam logic [7:0] RTD_A_IND_ADDR = 8'h1E;
   localparam logic [7:0] RTD_A_IND_WRITE = 8'h1F;
   localparam logic [7:0] RTD_A_LINEFEED = 8'h40;
   localparam logic [7:0] RTD_A_STATUS = 8'h44;
   localparam logic [7:0] RTD_A_DEBOUNCE = 8'h46;
   localparam logic [7:0] RTD_A_LOOP_CURRENT = 8'h4F;

   // Indirect register addresses
   localparam logic [7:0] RTD_I_THRESHOLD = 8'h1D;
   localparam logic [7:0] RTD_I_FILTER_COEFF = 8'h24;

   // Field layouts
   localparam int RTD_TRIP_BIT = 0;
   localparam int RTD_THR_LSB = 8;
   localparam int RTD_THR_W = 6;
   localparam int RTD_COEF_LSB = 3;
   localparam int RTD_COEF_W = 13;
   localparam int RTD_DEB_W = 7;
   localparam int RTD_LF_W = 3;
   localparam int RTD_LF_SHADOW_LSB = 4;
   localparam logic [2:0] RTD_LF_RINGING = 3'b100;

   // Reset values
   localparam logic [7:0] RTD_RST_BYTE = 8'h00;
   localparam logic [15:0] RTD_RST_WORD = 16'h0000;

   // Filter arithmetic: fraction bits of the state, coefficient scale
   localparam int RTD_FILT_FRAC = 8;
   localparam int RTD_COEF_SHIFT = 13;

   // Timing, in ns, and clock period
   localparam int RTD_CLK_PERIOD_NS = 10;
   localparam int RTD_SAMPLE_PERIOD_NS = 125000;
   localparam int RTD_DEB_LSB_NS = 1000000;
   localparam int RTD_SAMPLE_CYCLES =
      RTD_SAMPLE_PERIOD_NS / RTD_CLK_PERIOD_NS;
   localparam int RTD_DEB_LSB_CYCLES = RTD_DEB_LSB_NS / RTD_CLK_PERIOD_NS;

endpackage

// file: design/rtd_debounce.sv
/*
 * Debounce filter for the trip comparator output.
 * Assumes a one-cycle tick that sets the unit of the interval.
 */
`timescale 1ns/100ps
`default_nettype none

module rtd_debounce
   import rtd_pkg::*;
#(
   parameter int DEB_W = RTD_DEB_W
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic tick,
   input wire logic rawIn,
   input wire logic [DEB_W-1:0] interval,
   output logic cleanOut
);

   if (DEB_W < 1) begin : bad_width
      $error("rtd_debounce: DEB_W must be at least 1");
   end

   logic [DEB_W-1:0] holdCount; // Ticks spent in the opposite state
   wire logic differs = rawIn != cleanOut;
   wire logic expired = tick && (holdCount >= interval);
   wire logic [DEB_W-1:0] next_holdCount =
      !differs ? '0 : (tick ? holdCount + 1'b1 : holdCount);

   // Output flips only after a full interval of opposite input
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cleanOut <= 1'b0;
         holdCount <= '0;
      end else if (differs && expired) begin
         cleanOut <= rawIn;
         holdCount <= '0;
      end else begin
         holdCount <= next_holdCount;
      end
   end

endmodule

`default_nettype wire

// file: design/ring_trip_detector.sv
/*
 * Ring trip detector: input sampling, low-pass filter, threshold
 * comparator, debounce, status and interrupt pending, and the direct
 * and indirect register access for its settings.
 * Assumes a decoded 8-bit register port and a loop current code from
 * the current monitor that is asynchronous to ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module ring_trip_detector
   import rtd_pkg::*;
#(
   parameter int SAMPLE_CYCLES = RTD_SAMPLE_CYCLES,
   parameter int DEB_LSB_CYCLES = RTD_DEB_LSB_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [RTD_AW-1:0] regAddr,
   input wire logic [RTD_DW-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [RTD_DW-1:0] regRdData,
   input wire logic [RTD_DW-1:0] loopCurrentIn,
   output logic tripIrq,
   output logic ringingActive
);

   // Refuse counts that the tick dividers cannot serve
   if (SAMPLE_CYCLES < 1 || DEB_LSB_CYCLES < 1) begin : bad_counts
      $error("ring_trip_detector: tick counts must be at least 1");
   end

   // Fields must fit the indirect word; threshold fits the integer part
   if (RTD_THR_LSB + RTD_THR_W > RTD_IW ||
      RTD_COEF_LSB + RTD_COEF_W > RTD_IW ||
      RTD_THR_W > RTD_IW - RTD_FILT_FRAC) begin : bad_layout
      $error("ring_trip_detector: field layout does not fit");
   end

   // Divider widths and terminal counts
   localparam int SW = $clog2(SAMPLE_CYCLES + 1);
   localparam int DW = $clog2(DEB_LSB_CYCLES + 1);
   localparam logic [SW-1:0] SAMPLE_LAST = SW'(SAMPLE_CYCLES - 1);
   localparam logic [DW-1:0] DEB_LAST = DW'(DEB_LSB_CYCLES - 1);

   // Address match, used by every write decode
   function automatic logic hit(input logic [RTD_AW-1:0] a,
                                input logic [RTD_AW-1:0] b);
      hit = a == b;
   endfunction

   // Loop current synchroniser and accepted value
   logic [RTD_DW-1:0] lcSync1; // First stage, read only by the second
   logic [RTD_DW-1:0] lcSync2; // Second stage
   logic [RTD_DW-1:0] lcSync3; // Third stage
   logic [RTD_DW-1:0] loopCurrentValue; // Stable value of the sense code

   // Registers
   logic [RTD_DW-1:0] tripIrqPending; // Pending byte, bit 0 used
   logic [RTD_DW-1:0] tripIrqEnable; // Enable byte, bit 0 used
   logic [RTD_LF_W-1:0] linefeedControl; // Written linefeed code
   logic [RTD_LF_W-1:0] linefeedShadow; // State the line is in
   logic [RTD_DEB_W-1:0] tripDebounceInterval; // Debounce in ticks
   logic [RTD_IW-1:0] tripThresholdWord; // Indirect threshold word
   logic [RTD_IW-1:0] tripFilterCoeffWord; // Indirect coefficient word
   logic [RTD_IW-1:0] indData; // Indirect data pair
   logic [RTD_AW-1:0] indAddr; // Last indirect address read

   // Datapath state
   logic [SW-1:0] sampleCount; // Divider for the sample rate
   logic [DW-1:0] debCount; // Divider for the debounce unit
   logic sampleTick; // One cycle per sample
   logic debTick; // One cycle per debounce unit
   logic [RTD_IW-1:0] filt; // Filter state, 8.8 fixed point
   logic compareOut; // Comparator result
   logic tripDetected; // Debounced trip
   logic tripDetectedDly; // Previous value, for edge finding

   // Write strobes
   wire logic wrPending = regWrite && hit(regAddr, RTD_A_IRQ_PENDING);
   wire logic wrEnable = regWrite && hit(regAddr, RTD_A_IRQ_ENABLE);
   wire logic wrDataLo = regWrite && hit(regAddr, RTD_A_IND_DATA_LO);
   wire logic wrDataHi = regWrite && hit(regAddr, RTD_A_IND_DATA_HI);
   wire logic wrIndAddr = regWrite && hit(regAddr, RTD_A_IND_ADDR);
   wire logic wrIndWrite = regWrite && hit(regAddr, RTD_A_IND_WRITE);
   wire logic wrLinefeed = regWrite && hit(regAddr, RTD_A_LINEFEED);
   wire logic wrDebounce = regWrite && hit(regAddr, RTD_A_DEBOUNCE);

   // Indirect commit targets, selected by the written address
   wire logic indWrThr = wrIndWrite && hit(regWrData, RTD_I_THRESHOLD);
   wire logic indWrCoef = wrIndWrite && hit(regWrData, RTD_I_FILTER_COEFF);

   // Indirect read source for the address just written
   wire logic [RTD_IW-1:0] indReadWord =
      hit(regWrData, RTD_I_THRESHOLD) ? tripThresholdWord :
      hit(regWrData, RTD_I_FILTER_COEFF) ? tripFilterCoeffWord :
      RTD_RST_WORD;

   // Settings unpacked from the indirect words
   wire logic [RTD_THR_W-1:0] tripThreshold =
      tripThresholdWord[RTD_THR_LSB +: RTD_THR_W];
   wire logic [RTD_COEF_W-1:0] tripFilterCoeff =
      tripFilterCoeffWord[RTD_COEF_LSB +: RTD_COEF_W];

   // Ringing state as seen through the shadow
   wire logic ringing = linefeedShadow == RTD_LF_RINGING;

   // Low-pass filter step: filt += (x - filt) * coeff / 2^13
   wire logic signed [RTD_IW:0] filtDiff =
      $signed({1'b0, loopCurrentValue, {RTD_FILT_FRAC{1'b0}}}) -
      $signed({1'b0, filt});
   wire logic signed [RTD_IW+RTD_COEF_W+1:0] filtProd =
      filtDiff * $signed({1'b0, tripFilterCoeff});
   wire logic signed [RTD_IW+RTD_COEF_W+1:0] filtStep =
      filtProd >>> RTD_COEF_SHIFT;
   wire logic [RTD_IW-1:0] next_filt = filt + filtStep[RTD_IW-1:0];

   // Integer part of the filter against the threshold
   wire logic next_compareOut =
      filt[RTD_IW-1:RTD_FILT_FRAC] > {2'b00, tripThreshold};

   // Pending set on a new trip while enabled; set wins over a write-one clear
   wire logic tripRise = tripDetected && !tripDetectedDly;
   wire logic pendSet = tripRise && tripIrqEnable[RTD_TRIP_BIT];
   // Clear is write-one on bit 0; the rest of the byte is ignored
   wire logic pendClr = wrPending && regWrData[RTD_TRIP_BIT];
   wire logic next_pend =
      pendSet || (tripIrqPending[RTD_TRIP_BIT] && !pendClr);

   // Read selection
   wire logic [RTD_DW-1:0] next_regRdData =
      hit(regAddr, RTD_A_IRQ_PENDING) ? tripIrqPending :
      hit(regAddr, RTD_A_IRQ_ENABLE) ? tripIrqEnable :
      hit(regAddr, RTD_A_IND_DATA_LO) ? indData[RTD_DW-1:0] :
      hit(regAddr, RTD_A_IND_DATA_HI) ? indData[RTD_IW-1:RTD_DW] :
      hit(regAddr, RTD_A_IND_ADDR) ? indAddr :
      hit(regAddr, RTD_A_LINEFEED) ?
         {1'b0, linefeedShadow, 1'b0, linefeedControl} :
      hit(regAddr, RTD_A_STATUS) ?
         {{(RTD_DW-1){1'b0}}, tripDetected} :
      hit(regAddr, RTD_A_DEBOUNCE) ? {1'b0, tripDebounceInterval} :
      hit(regAddr, RTD_A_LOOP_CURRENT) ? loopCurrentValue :
      RTD_RST_BYTE;

   // Three-stage sampling of the loop current code
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lcSync1 <= RTD_RST_BYTE;
         lcSync2 <= RTD_RST_BYTE;
         lcSync3 <= RTD_RST_BYTE;
         loopCurrentValue <= RTD_RST_BYTE;
      end else begin
         lcSync1 <= loopCurrentIn;
         lcSync2 <= lcSync1;
         lcSync3 <= lcSync2;
         // Take the code only when two stages agree, never mid-change
         if (lcSync2 == lcSync3) begin
            loopCurrentValue <= lcSync3;
         end
      end
   end

   // Sample and debounce tick dividers
   // Ticks are registered, so each lands one cycle after terminal count
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sampleCount <= '0;
         debCount <= '0;
         sampleTick <= 1'b0;
         debTick <= 1'b0;
      end else begin
         sampleTick <= sampleCount == SAMPLE_LAST;
         debTick <= debCount == DEB_LAST;
         sampleCount <= (sampleCount == SAMPLE_LAST) ? '0 :
                        sampleCount + 1'b1;
         debCount <= (debCount == DEB_LAST) ? '0 : debCount + 1'b1;
      end
   end

   // Direct settings and linefeed shadow
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tripIrqEnable <= RTD_RST_BYTE;
         linefeedControl <= '0;
         linefeedShadow <= '0;
         tripDebounceInterval <= '0;
      end else begin
         if (wrEnable) begin
            tripIrqEnable <= regWrData;
         end
         if (wrLinefeed) begin
            linefeedControl <= regWrData[RTD_LF_W-1:0];
         end
         // Shadow trails the written code by one cycle
         linefeedShadow <= linefeedControl;
         if (wrDebounce) begin
            tripDebounceInterval <= regWrData[RTD_DEB_W-1:0];
         end
      end
   end

   // Indirect access through the data, address and write registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         indData <= RTD_RST_WORD;
         indAddr <= RTD_RST_BYTE;
         tripThresholdWord <= RTD_RST_WORD;
         tripFilterCoeffWord <= RTD_RST_WORD;
      end else begin
         if (wrDataLo) begin
            indData[RTD_DW-1:0] <= regWrData;
         end
         if (wrDataHi) begin
            indData[RTD_IW-1:RTD_DW] <= regWrData;
         end
         // An address write loads the pair so both halves read back
         if (wrIndAddr) begin
            indAddr <= regWrData;
            indData <= indReadWord;
         end
         if (indWrThr) begin
            tripThresholdWord <= indData;
         end
         if (indWrCoef) begin
            tripFilterCoeffWord <= indData;
         end
      end
   end

   // Filter runs on sample ticks only while ringing; cleared otherwise
   // Leaving ringing wipes the filter but not the debounced state
   always_ff @(posedge ref_clk) begin
      if (rst || !ringing) begin
         filt <= RTD_RST_WORD;
      end else if (sampleTick) begin
         filt <= next_filt;
      end
   end

   // Comparator output registered into the debounce stage
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         compareOut <= 1'b0;
      end else begin
         compareOut <= next_compareOut;
      end
   end

   // Debounce of the comparator result; its output is the status bit
   rtd_debounce #(
      .DEB_W(RTD_DEB_W)
   ) u_debounce (
      .ref_clk(ref_clk),
      .rst(rst),
      .tick(debTick),
      .rawIn(compareOut),
      .interval(tripDebounceInterval),
      .cleanOut(tripDetected)
   );

   // Pending bit: sticky, write one to clear; status has no write path
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tripDetectedDly <= 1'b0;
         tripIrqPending <= RTD_RST_BYTE;
         tripIrq <= 1'b0;
      end else begin
         tripDetectedDly <= tripDetected;
         tripIrqPending[RTD_TRIP_BIT] <= next_pend;
         tripIrq <= next_pend;
      end
   end

   // Register read data and ringing indicator
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         regRdData <= RTD_RST_BYTE;
         ringingActive <= 1'b0;
      end else begin
         // Read data holds between strobes
         if (regRead) begin
            regRdData <= next_regRdData;
         end
         ringingActive <= ringing;
      end
   end

endmodule

`default_nettype wire

// file: verif/rtd_subscriber.sv
/* Far-end terminal seen through the loop current sense code.
   Assumes the bench drives the hook state. */
`timescale 1ns/100ps
`default_nettype none
module rtd_subscriber
   import rtd_pkg::*;
#(
   parameter logic [7:0] ON_CODE = 8'h10,
   parameter logic [7:0] OFF_CODE = 8'hC0
) (
   input wire logic offHook,
   output wire logic [RTD_DW-1:0] loopCurrentIn
);
   // Low leakage on hook, large loop current once the handset lifts
   assign loopCurrentIn = offHook ? OFF_CODE : ON_CODE;
endmodule
`default_nettype wire

// file: verif/ring_trip_detector_properties.sv
/* Port checker for the ring trip detector.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
`default_nettype none
module rtd_checker
   import rtd_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [RTD_AW-1:0] regAddr,
   input wire logic [RTD_DW-1:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [RTD_DW-1:0] regRdData,
   input wire logic [RTD_DW-1:0] loopCurrentIn,
   input wire logic tripIrq,
   input wire logic ringingActive
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic enCopy; // Shadow of the interrupt enable bit
   wire logic clrPend = regWrite && regAddr == RTD_A_IRQ_PENDING
      && regWrData[0];
   wire logic lfWr = regWrite && regAddr == RTD_A_LINEFEED;
   // Follow software writes to the enable bit
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         enCopy <= 1'b0;
      end else if (regWrite && regAddr == RTD_A_IRQ_ENABLE) begin
         enCopy <= regWrData[0];
      end
   end
   property p_lcs_read;
      $stable(loopCurrentIn)[*6] ##0 (regRead
      && regAddr == RTD_A_LOOP_CURRENT) |=> regRdData == $past(loopCurrentIn);
   endproperty
   a_lcs_read: assert property (p_lcs_read)
      else $error("loop current read wrong");
   property p_rd_pend;
      regRead && regAddr == RTD_A_IRQ_PENDING
      |=> regRdData[0] == $past(tripIrq);
   endproperty
   a_rd_pend: assert property (p_rd_pend)
      else $error("pending read differs from irq");
   property p_irq_en;
      $rose(tripIrq) |-> $past(enCopy);
   endproperty
   a_irq_en: assert property (p_irq_en)
      else $error("irq raised while disabled");
   property p_irq_hold;
      $fell(tripIrq) |-> $past(clrPend) || $past(clrPend, 2);
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("irq dropped without clear");
   property p_ring_on;
      lfWr && regWrData[2:0] == RTD_LF_RINGING |-> ##[1:4] ringingActive;
   endproperty
   a_ring_on: assert property (p_ring_on)
      else $error("ringing not entered");
   property p_ring_off;
      lfWr && regWrData[2:0] != RTD_LF_RINGING |-> ##[1:4] !ringingActive;
   endproperty
   a_ring_off: assert property (p_ring_off)
      else $error("ringing not left");
   property p_trip_ring;
      $rose(tripIrq) |-> $past(ringingActive, 2);
   endproperty
   a_trip_ring: assert property (p_trip_ring)
      else $error("trip outside ringing");
   property p_unmapped;
      regRead && regAddr == 8'h7F |=> regRdData == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
endmodule
bind ring_trip_detector rtd_checker u_chk (.ref_clk(ref_clk), .rst(rst),
   .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite),
   .regRead(regRead), .regRdData(regRdData), .loopCurrentIn(loopCurrentIn),
   .tripIrq(tripIrq), .ringingActive(ringingActive));
`default_nettype wire

// file: verif/ring_trip_detector_tb_top.sv
/* Self-checking bench for the ring trip detector.
   Assumes shortened sample and debounce units. */
`timescale 1ns/100ps
`default_nettype none
module ring_trip_detector_tb_top
   import rtd_pkg::*;
();
   localparam int DEB = 8; // Debounce unit in clocks
   localparam logic [7:0] ON = 8'h10; // On-hook current code
   logic ref_clk, rst, regWrite, regRead, offHook, tripIrq, ringingActive;
   logic [7:0] regAddr, regWrData, regRdData, loopCurrentIn, v;
   logic [15:0] w; // Indirect word read back
   int n_errors = 0, cmp_count = 0, cycles = 0, n;
   ring_trip_detector #(.SAMPLE_CYCLES(4), .DEB_LSB_CYCLES(DEB)) dut (
      .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData), .loopCurrentIn(loopCurrentIn),
      .tripIrq(tripIrq), .ringingActive(ringingActive));
   rtd_subscriber #(.ON_CODE(ON), .OFF_CODE(8'hC0)) u_sub (
      .offHook(offHook), .loopCurrentIn(loopCurrentIn));
   // Free-running 100 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // Hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_errors++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("Checks %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [15:0] g,
                      input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         n_errors++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask
   // One write strobe, then one idle cycle
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrite = 1'b1;
      @(negedge ref_clk);
      regWrite = 1'b0;
      @(negedge ref_clk);
   endtask
   // Read data lands one cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      regAddr = a;
      regRead = 1'b1;
      @(negedge ref_clk);
      regRead = 1'b0;
      d = regRdData;
      @(negedge ref_clk);
   endtask
   task automatic rchk(input string s, input logic [7:0] a,
                       input logic [7:0] e);
      rd(a, v);
      chk(s, {8'h00, v}, {8'h00, e});
   endtask
   task automatic iwr(input logic [7:0] ia, input logic [15:0] d);
      wr(RTD_A_IND_DATA_LO, d[7:0]);
      wr(RTD_A_IND_DATA_HI, d[15:8]);
      wr(RTD_A_IND_WRITE, ia);
   endtask
   task automatic ird(input logic [7:0] ia, output logic [15:0] d);
      wr(RTD_A_IND_ADDR, ia);
      rd(RTD_A_IND_DATA_LO, d[7:0]);
      rd(RTD_A_IND_DATA_HI, d[15:8]);
   endtask
   task automatic idle(input int c);
      repeat (c) @(negedge ref_clk);
   endtask
   // Main sequence
   initial begin
      rst = 1'b1;
      {regAddr, regWrData, regWrite, regRead, offHook} = '0;
      idle(6);
      rst = 1'b0;
      idle(8);
      rchk("enable", RTD_A_IRQ_ENABLE, RTD_RST_BYTE);
      rchk("debounce", RTD_A_DEBOUNCE, RTD_RST_BYTE);
      rchk("loop", RTD_A_LOOP_CURRENT, ON);
      rchk("unmapped", 8'h7F, 8'h00);
      wr(RTD_A_STATUS, 8'hFF);
      rchk("status ro", RTD_A_STATUS, 8'h00);
      wr(RTD_A_DEBOUNCE, 8'h0B);
      rchk("debounce", RTD_A_DEBOUNCE, 8'h0B);
      wr(RTD_A_IRQ_ENABLE, 8'h01);
      rchk("enable", RTD_A_IRQ_ENABLE, 8'h01);
      iwr(RTD_I_THRESHOLD, 16'h3600);
      ird(RTD_I_THRESHOLD, w);
      chk("threshold", w, 16'h3600);
      iwr(RTD_I_FILTER_COEFF, 16'h0320);
      ird(RTD_I_FILTER_COEFF, w);
      chk("coeff", w, 16'h0320);
      // Off hook outside ringing must not trip
      offHook = 1'b1;
      idle(400);
      rchk("idle trip", RTD_A_STATUS, 8'h00);
      offHook = 1'b0;
      wr(RTD_A_LINEFEED, {5'h00, RTD_LF_RINGING});
      idle(4);
      chk("ringing", {15'h0, ringingActive}, 16'h1);
      idle(600);
      rchk("below thr", RTD_A_STATUS, 8'h00);
      // Lift the handset and time the trip
      offHook = 1'b1;
      n = 0;
      while (tripIrq !== 1'b1 && n < 3000) begin
         idle(1);
         n++;
      end
      chk("trip late", 16'(n >= 3000), 16'h0);
      chk("trip early", 16'(n < 8'h0B * DEB), 16'h0);
      rchk("status", RTD_A_STATUS, 8'h01);
      rchk("pending", RTD_A_IRQ_PENDING, 8'h01);
      // Release clears the status but not the pending bit
      offHook = 1'b0;
      idle(600);
      rchk("released", RTD_A_STATUS, 8'h00);
      chk("held irq", {15'h0, tripIrq}, 16'h1);
      wr(RTD_A_IRQ_PENDING, 8'h01);
      chk("cleared", {15'h0, tripIrq}, 16'h0);
      // A zero coefficient freezes the filter
      iwr(RTD_I_FILTER_COEFF, 16'h0000);
      offHook = 1'b1;
      idle(600);
      rchk("frozen", RTD_A_STATUS, 8'h00);
      // Trip with the interrupt disabled
      wr(RTD_A_IRQ_ENABLE, 8'h00);
      iwr(RTD_I_FILTER_COEFF, 16'h0320);
      idle(800);
      rchk("masked st", RTD_A_STATUS, 8'h01);
      wr(RTD_A_STATUS, 8'h00);
      rchk("status ro", RTD_A_STATUS, 8'h01);
      chk("masked irq", {15'h0, tripIrq}, 16'h0);
      wr(RTD_A_LINEFEED, 8'h00);
      idle(4);
      chk("ring off", {15'h0, ringingActive}, 16'h0);
      end_sim();
   end
endmodule
`default_nettype wire
